// ---- common/bpa_pkg.sv ----
// Package: shared constants and types of the bus priority arbiter
package bpa_pkg;
    localparam int NLEV = 4;
    localparam int DEVS = 2;
    localparam int VW = 8;
    localparam int PW = 3;
    localparam int CPU_AW = 16;
    localparam int BUS_AW = 18;
    localparam int DW = 16;
    localparam logic [2:0] IO_PAGE_TOP = 3'h7;
    localparam logic [1:0] EXT_ONES = 2'h3;
    localparam logic [1:0] EXT_ZEROS = 2'h0;
    localparam logic [PW-1:0] PRI_RESET = 3'h7;
    localparam int LEV_BASE = 4;
    localparam logic [1:0] OWN_CPU = 2'h0;
    localparam logic [1:0] OWN_DMA = 2'h1;
    localparam logic [1:0] OWN_INT = 2'h2;
    localparam logic [1:0] OWN_CON = 2'h3;
    typedef enum logic [2:0] {
        BPA_IDLE = 3'h0,
        BPA_GRANT = 3'h1,
        BPA_OWNED = 3'h3,
        BPA_VECT = 3'h2,
        BPA_CYCLE = 3'h6
    } bpa_state_t;
endpackage

// ---- common/bpa_if.sv ----
// Interface: arbitration lines between processor and requesting devices
`timescale 1ns/1ps
interface bpa_if;
    logic npr;
    logic npg;
    logic [bpa_pkg::NLEV-1:0] br;
    logic [bpa_pkg::NLEV-1:0] bg;
    logic sack;
    logic busy;
    logic intr;
    logic [bpa_pkg::VW-1:0] vector;
    modport cpu (input npr, br, sack, busy, intr, vector, output npg, bg);
    modport dev (output npr, br, sack, busy, intr, vector, input npg, bg);
endinterface

// ---- verilog/bpa_device_end.sv ----
// Peripheral end: requests bus, passes grants down a daisy chain
`timescale 1ns/1ps
module bpa_device_end
    import bpa_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Arbitration link
    bpa_if.dev bus,
    // User side, one entry per chained device, index 0 nearest the processor
    input wire logic [bpa_pkg::DEVS-1:0] wantDma,
    input wire logic [bpa_pkg::DEVS-1:0] wantInt,
    input wire logic [bpa_pkg::DEVS*2-1:0] devLevel,
    input wire logic [bpa_pkg::DEVS*bpa_pkg::VW-1:0] devVector,
    input wire logic [bpa_pkg::DEVS-1:0] doneDma,
    output logic [bpa_pkg::DEVS-1:0] ownDma,
    output logic [bpa_pkg::DEVS-1:0] intTaken
);
    import bpa_pkg::*;
    logic [DEVS-1:0] ownD, next_ownD, ownI, next_ownI;
    logic [DEVS-1:0] gotNpg, gotBg;
    logic nxNpr, nxSack, nxBusy, nxIntr;
    logic [NLEV-1:0] nxBr;
    logic [VW-1:0] nxVec;
    logic npr_q, sack_q, busy_q, intr_q;
    logic [NLEV-1:0] br_q;
    logic [VW-1:0] vec_q;

    // ************
    // Daisy chain
    // ************
    // Grant ripples from the nearest device; a requester absorbs it
    always_comb begin
        gotNpg = '0;
        gotBg = '0;
        for (int i = 0; i < DEVS; i++) begin
            if (i == 0) begin
                gotNpg[i] = bus.npg & wantDma[0];
                gotBg[i] = bus.bg[devLevel[1:0]] & wantInt[0];
            end else begin
                gotNpg[i] = bus.npg & wantDma[i];
                gotBg[i] = bus.bg[devLevel[2*i +: 2]] & wantInt[i];
                for (int j = 0; j < i; j++) begin
                    if (wantDma[j]) begin
                        gotNpg[i] = 1'b0;
                    end
                    if (wantInt[j] && devLevel[2*j +: 2] == devLevel[2*i +: 2]) begin
                        gotBg[i] = 1'b0;
                    end
                end
            end
        end
    end

    always_comb begin
        next_ownD = ownD;
        next_ownI = '0;
        nxNpr = |(wantDma & ~ownD);
        nxBr = '0;
        nxSack = 1'b0;
        nxBusy = |ownD;
        nxIntr = 1'b0;
        nxVec = '0;
        for (int i = 0; i < DEVS; i++) begin
            if (wantInt[i]) begin
                nxBr[devLevel[2*i +: 2]] = 1'b1;
            end
            if (ownD[i] && doneDma[i]) begin
                next_ownD[i] = 1'b0;
            end
            if (gotNpg[i] && !(|ownD)) begin
                next_ownD[i] = 1'b1;
                nxSack = 1'b1;
            end
            // Own vector on interrupt grant, one cycle
            // Grant stays up one cycle after an answer; only one device may take it
            if (gotBg[i] && !sack_q) begin
                next_ownI[i] = 1'b1;
                nxIntr = 1'b1;
                nxVec = devVector[VW*i +: VW];
                nxSack = 1'b1;
            end
        end
    end

    // Transfers run by the owner directly, memory never requests
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ownD <= '0;
            ownI <= '0;
            npr_q <= 1'b0;
            br_q <= '0;
            sack_q <= 1'b0;
            busy_q <= 1'b0;
            intr_q <= 1'b0;
            vec_q <= '0;
        end else begin
            ownD <= next_ownD;
            ownI <= next_ownI;
            npr_q <= nxNpr;
            br_q <= nxBr;
            sack_q <= nxSack;
            busy_q <= nxBusy;
            intr_q <= nxIntr;
            vec_q <= nxVec;
        end
    end

    assign bus.npr = npr_q;
    assign bus.br = br_q;
    assign bus.sack = sack_q;
    assign bus.busy = busy_q;
    assign bus.intr = intr_q;
    assign bus.vector = vec_q;
    assign ownDma = ownD;
    assign intTaken = ownI;
endmodule

// ---- verilog/bpa_cpu_end.sv ----
// Processor end: priority arbiter, vector capture and address extension
`timescale 1ns/1ps
module bpa_cpu_end
    import bpa_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Arbitration link
    bpa_if.cpu bus,
    // Processor sequencing
    input wire logic cycleEnd,
    input wire logic instrEnd,
    input wire logic waitTrap,
    input wire logic [bpa_pkg::PW-1:0] swPriority,
    input wire logic swPriorityLoad,
    input wire logic [bpa_pkg::CPU_AW-1:0] cpuAddr,
    input wire logic [bpa_pkg::DW-1:0] cpuData,
    // Console
    input wire logic consoleBusRequest,
    input wire logic depositSwitch,
    input wire logic examineSwitch,
    // Results
    output logic [bpa_pkg::BUS_AW-1:0] busAddr,
    output logic busWrite,
    output logic busRead,
    output logic [bpa_pkg::PW-1:0] procPriority,
    output logic [bpa_pkg::VW-1:0] vectorOut,
    output logic vectorValid,
    output logic consoleGrant,
    output logic [1:0] busOwner,
    output logic [bpa_pkg::BUS_AW-1:0] showAddr,
    output logic [bpa_pkg::DW-1:0] showData
);
    import bpa_pkg::*;
    bpa_state_t state, next_state;
    logic [1:0] owner, next_owner;
    logic npg, next_npg, cgnt, next_cgnt, vv, next_vv;
    logic [NLEV-1:0] bg, next_bg;
    logic [PW-1:0] pri, next_pri;
    logic [VW-1:0] vec, next_vec;
    logic [BUS_AW-1:0] ba, next_ba;
    logic wr, next_wr, rd, next_rd;
    logic [DW-1:0] sd, next_sd;
    logic [NLEV-1:0] lvlOk;
    logic [NLEV-1:0] pick;

    // ****************
    // Address extension
    // ****************
    function automatic logic [BUS_AW-1:0] extend(input logic [CPU_AW-1:0] a);
        if (a[CPU_AW-1 -: 3] == IO_PAGE_TOP) begin
            extend = {EXT_ONES, a};
        end else begin
            extend = {EXT_ZEROS, a};
        end
    endfunction

    // ****************
    // Level selection
    // ****************
    // Level i carries hardware priority LEV_BASE+i; only above processor
    always_comb begin
        pick = '0;
        lvlOk = '0;
        for (int i = 0; i < NLEV; i++) begin
            lvlOk[i] = bus.br[i] && (PW'(LEV_BASE + i) > pri);
        end
        for (int i = NLEV - 1; i >= 0; i--) begin
            if (lvlOk[i] && pick == '0) begin
                pick[i] = 1'b1;
            end
        end
    end

    // ****************
    // Arbiter
    // ****************
    always_comb begin
        next_state = state;
        next_owner = owner;
        next_npg = 1'b0;
        next_bg = '0;
        next_cgnt = cgnt;
        next_vv = 1'b0;
        next_vec = vec;
        next_pri = pri;
        // Routine priority is loaded by software alone, never from the device
        if (swPriorityLoad) begin
            next_pri = swPriority;
        end
        case (state)
            BPA_IDLE: begin
                next_owner = OWN_CPU;
                if (consoleBusRequest && instrEnd) begin
                    next_cgnt = 1'b1;
                    next_owner = OWN_CON;
                    next_state = BPA_CYCLE;
                end else if (bus.npr && (cycleEnd || waitTrap)) begin
                    next_npg = 1'b1;
                    next_state = BPA_GRANT;
                end else if (pick != '0 && instrEnd) begin
                    next_bg = pick;
                    next_state = BPA_GRANT;
                end
            end
            BPA_GRANT: begin
                next_npg = npg;
                next_bg = bg;
                if (bus.sack) begin
                    next_npg = 1'b0;
                    next_bg = '0;
                    if (bus.intr) begin
                        next_vec = bus.vector;
                        next_vv = 1'b1;
                        next_owner = OWN_INT;
                        next_state = BPA_VECT;
                    end else begin
                        next_owner = OWN_DMA;
                        next_state = BPA_OWNED;
                    end
                end else if (!bus.npr && bus.br == '0) begin
                    next_npg = 1'b0;
                    next_bg = '0;
                    next_state = BPA_IDLE;
                end
            end
            BPA_OWNED: begin
                // No new grant while the master holds the bus
                if (!bus.busy && !bus.sack) begin
                    next_state = BPA_IDLE;
                end
            end
            BPA_VECT: begin
                next_state = BPA_IDLE;
            end
            BPA_CYCLE: begin
                if (!consoleBusRequest) begin
                    next_cgnt = 1'b0;
                    next_state = BPA_IDLE;
                end
            end
            default: begin
                next_state = BPA_IDLE;
            end
        endcase
    end

    // Console deposit is a write, examine a read
    always_comb begin
        next_ba = extend(cpuAddr);
        next_wr = depositSwitch;
        next_rd = examineSwitch & ~depositSwitch;
        next_sd = cpuData;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= BPA_IDLE;
            owner <= OWN_CPU;
            npg <= 1'b0;
            bg <= '0;
            cgnt <= 1'b0;
            vv <= 1'b0;
            vec <= '0;
            pri <= PRI_RESET;
            ba <= '0;
            wr <= 1'b0;
            rd <= 1'b0;
            sd <= '0;
        end else begin
            state <= next_state;
            owner <= next_owner;
            npg <= next_npg;
            bg <= next_bg;
            cgnt <= next_cgnt;
            vv <= next_vv;
            vec <= next_vec;
            pri <= next_pri;
            ba <= next_ba;
            wr <= next_wr;
            rd <= next_rd;
            sd <= next_sd;
        end
    end

    assign bus.npg = npg;
    assign bus.bg = bg;
    assign busAddr = ba;
    assign busWrite = wr;
    assign busRead = rd;
    assign procPriority = pri;
    assign vectorOut = vec;
    assign vectorValid = vv;
    assign consoleGrant = cgnt;
    // Console display of owner, address and data
    assign busOwner = owner;
    assign showAddr = ba;
    assign showData = sd;
endmodule

// ---- tb/bpa_asserts.sv ----
// Checker of the arbitration link between the processor and device ends
`timescale 1ns/1ps
module bpa_asserts
    import bpa_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Link signals
    input wire logic npr,
    input wire logic npg,
    input wire logic [bpa_pkg::NLEV-1:0] br,
    input wire logic [bpa_pkg::NLEV-1:0] bg,
    input wire logic sack,
    input wire logic busy,
    input wire logic intr,
    input wire logic [bpa_pkg::VW-1:0] vector
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);
    // ****************
    // Grant exclusion
    // ****************
    chk_one_grant: assert property ($onehot0({npg, bg}))
        else $error("two grants at once");
    chk_busy_blocks: assert property (busy |-> !npg && bg == 4'h0)
        else $error("grant while bus held");
    chk_grant_drop: assert property (sack |=> !npg && bg == 4'h0)
        else $error("grant kept after accept");
    // ****************
    // Grant causes
    // ****************
    chk_npr_cause: assert property ($rose(npg) |-> $past(npr))
        else $error("dma grant without request");
    // Level granted must be requested and no higher level left waiting
    chk_level_top: assert property ($rose(|bg) |->
        |($past(br) & bg) && $past(br) < {bg, 1'h0})
        else $error("wrong level granted");
    // ****************
    // Device answers
    // ****************
    chk_dma_accept: assert property ($rose(npg) |=> sack)
        else $error("dma grant not accepted");
    chk_busy_follow: assert property (sack && !intr |=> busy)
        else $error("dma owner not holding bus");
    chk_vector_sack: assert property (intr |-> sack)
        else $error("vector without accept");
endmodule

// ---- tb/bus_priority_arbiter_address_extend_test.sv ----
// Testbench: processor and device ends joined over the arbitration link
`timescale 1ns/1ps
module bus_priority_arbiter_address_extend_test;
    import bpa_pkg::*;
    typedef struct {int kind; logic [56:0] val;} bpa_note_t;
    logic mclk, rst, cycleEnd, instrEnd, waitTrap, swPriorityLoad, consoleBusRequest;
    logic depositSwitch, examineSwitch, busWrite, busRead, vectorValid, consoleGrant, prevCon;
    logic [PW-1:0] swPriority, procPriority, pri;
    logic [CPU_AW-1:0] cpuAddr;
    logic [DW-1:0] cpuData, showData;
    logic [DEVS*VW-1:0] devVector;
    logic [BUS_AW-1:0] busAddr, showAddr;
    logic [VW-1:0] vectorOut;
    logic [1:0] busOwner;
    logic [DEVS-1:0] wantDma, wantInt, doneDma, ownDma, intTaken, heldOwn, heldInt;
    logic [DEVS*2-1:0] devLevel;
    int failCount, nCompared, cycles, seed, i;
    string what[4] = '{"address", "vector", "dma owner", "console grant"};
    bpa_note_t notes[$];
    bpa_if link();
    bpa_cpu_end bpa_cpu_end_inst (.mclk, .rst, .bus(link), .cycleEnd, .instrEnd, .waitTrap,
        .swPriority, .swPriorityLoad, .cpuAddr, .cpuData, .consoleBusRequest, .depositSwitch,
        .examineSwitch, .busAddr, .busWrite, .busRead, .procPriority, .vectorOut, .vectorValid,
        .consoleGrant, .busOwner, .showAddr, .showData);
    bpa_device_end bpa_device_end_inst (.mclk, .rst, .bus(link), .wantDma, .wantInt,
        .devLevel, .devVector, .doneDma, .ownDma, .intTaken);
    bpa_asserts bpa_asserts_inst (.mclk, .rst, .npr(link.npr), .npg(link.npg), .br(link.br),
        .bg(link.bg), .sack(link.sack), .busy(link.busy), .intr(link.intr),
        .vector(link.vector));
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    task stopTest;
        if (failCount == 0 && nCompared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            stopTest();
        end
    end
    task note(int k, logic [56:0] v);
        notes.push_back('{k, v});
    endtask
    task take(int k, logic [56:0] v);
        bpa_note_t n;
        if (notes.size() == 0 || notes[0].kind != k) begin
            failCount++;
            $display("wrong value %s expected none seen %h", what[k], v);
        end else begin
            n = notes.pop_front();
            nCompared++;
            if (v !== n.val) begin
                failCount++;
                $display("wrong value %s expected %h seen %h", what[k], n.val, v);
            end
        end
    endtask
    // Monitor, plus device users that release the bus a cycle after owning it
    always @(negedge mclk) begin
        if (notes.size() > 0 && notes[0].kind == 0)
            take(0, {busWrite, busRead, busAddr, showAddr, showData, procPriority});
        if (vectorValid)
            take(1, 57'({busOwner, vectorOut, heldInt}));
        if ((ownDma & heldOwn & ~doneDma) != 2'h0)
            take(2, 57'({busOwner, ownDma}));
        if (consoleGrant && !prevCon)
            take(3, 57'({busOwner, consoleGrant}));
        heldOwn <= ownDma;
        heldInt <= intTaken;
        prevCon <= consoleGrant;
        doneDma <= ownDma & heldOwn & ~doneDma;
        if (ownDma != 2'h0)
            wantDma <= wantDma & ~ownDma;
        if (intTaken != 2'h0)
            wantInt <= wantInt & ~intTaken;
    end
    task pulse(logic ie, logic ce, logic wt);
        @(negedge mclk);
        {instrEnd, cycleEnd, waitTrap} = {ie, ce, wt};
        @(negedge mclk);
        {instrEnd, cycleEnd, waitTrap} = 3'h0;
    endtask
    // Extra pulses after the last note catch grants that should not occur
    task run(logic ie, logic ce, logic wt);
        int n;
        for (n = 0; n < 30 && notes.size() > 0; n++)
            pulse(ie, ce, wt);
        repeat (4) pulse(ie, ce, wt);
        if (notes.size() > 0) begin
            failCount++;
            $display("wrong value pending notes expected 0 seen %0d", notes.size());
            notes.delete();
        end
    endtask
    task setPri(logic [2:0] p);
        @(negedge mclk);
        swPriority = p;
        swPriorityLoad = 1'h1;
        @(negedge mclk);
        swPriorityLoad = 1'h0;
        pri = p;
    endtask
    task addr(logic [15:0] a);
        logic [17:0] e;
        @(negedge mclk);
        cpuAddr = a;
        cpuData = 16'($random(seed));
        {depositSwitch, examineSwitch} = 2'($random(seed));
        e = (a[15:13] == IO_PAGE_TOP) ? {EXT_ONES, a} : {EXT_ZEROS, a};
        @(posedge mclk);
        note(0, {depositSwitch, examineSwitch & ~depositSwitch, e, e, cpuData, pri});
    endtask
    task intCase(logic [2:0] p, logic [1:0] l0, logic [1:0] l1, logic [1:0] w);
        logic ok0, ok1, first1;
        setPri(p);
        devVector = 16'($random(seed));
        devLevel = {l1, l0};
        ok0 = w[0] && ({1'h1, l0} > p);
        ok1 = w[1] && ({1'h1, l1} > p);
        first1 = ok1 && (!ok0 || l1 > l0);
        if (first1)
            note(1, 57'({OWN_INT, devVector[2*VW-1:VW], 2'h2}));
        if (ok0)
            note(1, 57'({OWN_INT, devVector[VW-1:0], 2'h1}));
        if (ok1 && !first1)
            note(1, 57'({OWN_INT, devVector[2*VW-1:VW], 2'h2}));
        @(negedge mclk);
        wantInt = w;
        run(1'h1, 1'h0, 1'h0);
        wantInt = 2'h0;
    endtask
    initial begin
        seed = 32'h6a87bbe8;
        {cycleEnd, instrEnd, waitTrap, swPriorityLoad, consoleBusRequest} = 5'h0;
        {depositSwitch, examineSwitch, prevCon} = 3'h0;
        {swPriority, pri, cpuAddr, cpuData, devVector, devLevel} = '0;
        {wantDma, wantInt, doneDma, heldOwn, heldInt} = 10'h0;
        rst = 1'h1;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        rst = 1'h0;
        setPri(3'h3);
        addr(16'hdfff);
        addr(16'he000);
        for (i = 0; i < 24; i++)
            addr(16'($random(seed)) | (i[0] ? 16'he000 : 16'h0));
        run(1'h0, 1'h0, 1'h0);
        {depositSwitch, examineSwitch} = 2'h0;
        intCase(3'h3, 2'h1, 2'h1, 2'h3);
        intCase(3'h3, 2'h0, 2'h3, 2'h3);
        intCase(3'h5, 2'h2, 2'h1, 2'h3);
        intCase(3'h6, 2'h2, 2'h3, 2'h3);
        intCase(3'h4, 2'h0, 2'h2, 2'h1);
        intCase(3'h7, 2'h3, 2'h3, 2'h3);
        wantDma = 2'h2;
        run(1'h1, 1'h0, 1'h0);
        note(2, 57'({OWN_DMA, 2'h2}));
        run(1'h0, 1'h1, 1'h0);
        wantDma = 2'h3;
        note(2, 57'({OWN_DMA, 2'h1}));
        note(2, 57'({OWN_DMA, 2'h2}));
        run(1'h0, 1'h0, 1'h1);
        setPri(3'h3);
        wantDma = 2'h2;
        wantInt = 2'h1;
        note(2, 57'({OWN_DMA, 2'h2}));
        note(1, 57'({OWN_INT, devVector[VW-1:0], 2'h1}));
        run(1'h1, 1'h1, 1'h0);
        consoleBusRequest = 1'h1;
        wantInt = 2'h1;
        note(3, 57'({OWN_CON, 1'h1}));
        run(1'h1, 1'h0, 1'h0);
        consoleBusRequest = 1'h0;
        note(1, 57'({OWN_INT, devVector[VW-1:0], 2'h1}));
        run(1'h1, 1'h0, 1'h0);
        stopTest();
    end
endmodule
